// *** logic/bus_common_cfg.svh ***
// Constants for the bus common control register block
`ifndef BUS_COMMON_CFG_SVH
`define BUS_COMMON_CFG_SVH

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define BCC_OFFSET        12'h000
`define BCC_ADDR_W        12

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define BCC_MAP_BIT       12
`define BCC_ONE4_BIT      4
`define BCC_ENDIAN_BIT    3
`define BCC_ONE2_BIT      2
`define BCC_MEMDRV_BIT    1
`define BCC_CLKDRV_BIT    0

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define BCC_MAP_RST       1'b0
`define BCC_MEMDRV_RST    1'b0
`define BCC_CLKDRV_RST    1'b0

// ---------------------------------------------------------------
// Bus responses
// ---------------------------------------------------------------
`define AXI_RESP_OKAY     2'h0
`define AXI_RESP_SLVERR   2'h2

`endif

// *** logic/bus_common_pkg.sv ***
// Types shared by the bus common control register block
`default_nettype none
package bus_common_pkg;
   // Write channel sequencing states, one-hot
   typedef enum logic [2:0] {
      WR_IDLE = 3'b001,
      WR_HALF = 3'b010,
      WR_RESP = 3'b100
   } wr_state_t;
   // Read channel sequencing states, one-hot
   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_RESP = 2'b10
   } rd_state_t;
endpackage
`default_nettype wire

// *** logic/strap_capture.sv ***
// Capture of the byte order mode pin after reset release
`timescale 1ns/1ps
`default_nettype none
module strap_capture (
   input  wire logic mclk,
   input  wire logic nrst,
   input  wire logic ce,
   input  wire logic strap_in,
   output logic      strap_val
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic done_r;    // Capture has happened
   logic done_nxt;
   logic val_r;     // Captured level
   logic val_nxt;

   // Take the pin once on the first enabled edge after release;
   // the async reset only loads constants, never the pin itself
   always_comb begin
      done_nxt = done_r;
      val_nxt  = val_r;
      if (!done_r) begin
         done_nxt = 1'b1;
         val_nxt  = strap_in;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         done_r <= 1'b0;
         val_r  <= 1'b0;
      end else if (ce) begin
         done_r <= done_nxt;
         val_r  <= val_nxt;
      end
   end

   assign strap_val = val_r;
endmodule
`default_nettype wire

// *** logic/bus_common_control.sv ***
// Bus common control register with AXI4-Lite slave
//
// Behaviour
// - Bits 31:13 and 11:5 read zero
// - Bits 4 and 2 always read one
// - Bit 12 selects address map one or two
// - Bit 3 captures mode pin, read-only
// - Pin low reads zero big, high one little
// - Captured byte order governs every address space
// - Bit 1 keeps memory pins driven in standby
// - Bit 0 keeps clock/strobe pins driven in standby
// - Map two: areas 5,6 take card memory
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "bus_common_cfg.svh"
module bus_common_control
   import bus_common_pkg::*;
#(
   parameter int ADDR_W = `BCC_ADDR_W
) (
   input  wire logic              mclk,
   input  wire logic              nrst,
   input  wire logic              ce,
   // AXI4-Lite write address
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Mode pin and governed settings
   input  wire logic              byte_order_mode_pin,
   output logic                   map_select,
   output logic                   little_endian,
   output logic                   standby_memory_pin_drive,
   output logic                   standby_clock_pin_drive,
   output logic                   area5_card_enable,
   output logic                   area6_card_enable
);
   // ---------------------------------------------------------------
   // Decode helpers
   // ---------------------------------------------------------------
   // Register hit check, used by both channels
   function automatic logic hit(input logic [ADDR_W-1:0] a);
      hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(ADDR_W'(`BCC_OFFSET) >> 2));
   endfunction

   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   logic map_r;           // Address map select
   logic map_nxt;
   logic memdrv_r;        // Memory pins driven in standby
   logic memdrv_nxt;
   logic clkdrv_r;        // Clock/strobe pins driven in standby
   logic clkdrv_nxt;
   logic endian_cap;      // Captured byte order level
   logic endian_r;        // Registered copy for the output pin
   logic card5_r;
   logic card6_r;

   // ---------------------------------------------------------------
   // Write channel state
   // ---------------------------------------------------------------
   wr_state_t         wst_r;
   wr_state_t         wst_nxt;
   logic              aw_have_r;   // Address already taken
   logic              aw_have_nxt;
   logic              w_have_r;    // Data already taken
   logic              w_have_nxt;
   logic [ADDR_W-1:0] awaddr_r;
   logic [ADDR_W-1:0] awaddr_nxt;
   logic [31:0]       wdata_r;
   logic [31:0]       wdata_nxt;
   logic [3:0]        wstrb_r;
   logic [3:0]        wstrb_nxt;
   logic              awready_r;
   logic              awready_nxt;
   logic              wready_r;
   logic              wready_nxt;
   logic              bvalid_r;
   logic              bvalid_nxt;
   logic [1:0]        bresp_r;
   logic [1:0]        bresp_nxt;

   // ---------------------------------------------------------------
   // Read channel state
   // ---------------------------------------------------------------
   rd_state_t   rst_r;
   rd_state_t   rst_nxt;
   logic        arready_r;
   logic        arready_nxt;
   logic        rvalid_r;
   logic        rvalid_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic [1:0]  rresp_r;
   logic [1:0]  rresp_nxt;
   logic [31:0] reg_view;   // Current read image of the register

   // ---------------------------------------------------------------
   // Mode pin capture
   // ---------------------------------------------------------------
   strap_capture u_strap (
      .mclk      (mclk),
      .nrst      (nrst),
      .ce        (ce),
      .strap_in  (byte_order_mode_pin),
      .strap_val (endian_cap)
   );

   // Read image: fixed ones and zeros are built in, not stored
   always_comb begin
      reg_view                  = 32'h0000_0000;
      reg_view[`BCC_MAP_BIT]    = map_r;
      reg_view[`BCC_ONE4_BIT]   = 1'b1;
      reg_view[`BCC_ONE2_BIT]   = 1'b1;
      reg_view[`BCC_ENDIAN_BIT] = endian_cap;
      reg_view[`BCC_MEMDRV_BIT] = memdrv_r;
      reg_view[`BCC_CLKDRV_BIT] = clkdrv_r;
   end

   // ---------------------------------------------------------------
   // Write path
   // ---------------------------------------------------------------
   // Address and data accepted in either order; one write at a time
   always_comb begin
      wst_nxt     = wst_r;
      aw_have_nxt = aw_have_r;
      w_have_nxt  = w_have_r;
      awaddr_nxt  = awaddr_r;
      wdata_nxt   = wdata_r;
      wstrb_nxt   = wstrb_r;
      awready_nxt = 1'b0;
      wready_nxt  = 1'b0;
      bvalid_nxt  = bvalid_r;
      bresp_nxt   = bresp_r;
      map_nxt     = map_r;
      memdrv_nxt  = memdrv_r;
      clkdrv_nxt  = clkdrv_r;
      unique case (wst_r)
         WR_IDLE, WR_HALF: begin
            // Take address when offered and not yet held
            if (s_axi_awvalid && awready_r) begin
               aw_have_nxt = 1'b1;
               awaddr_nxt  = s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_r) begin
               w_have_nxt = 1'b1;
               wdata_nxt  = s_axi_wdata;
               wstrb_nxt  = s_axi_wstrb;
            end
            if (aw_have_nxt && w_have_nxt) begin
               wst_nxt = WR_RESP;
            end else begin
               wst_nxt     = (aw_have_nxt || w_have_nxt) ? WR_HALF : WR_IDLE;
               // Ready is raised one cycle ahead, dropped once taken
               awready_nxt = !aw_have_nxt && !(s_axi_awvalid && awready_r);
               wready_nxt  = !w_have_nxt && !(s_axi_wvalid && wready_r);
            end
         end
         WR_RESP: begin
            // Commit the held write and raise the response
            if (!bvalid_r) begin
               bvalid_nxt = 1'b1;
               if (hit(awaddr_r)) begin
                  bresp_nxt = `AXI_RESP_OKAY;
                  // Only the low two lanes hold writable bits; the rest is dropped
                  if (wstrb_r[1]) begin
                     map_nxt = wdata_r[`BCC_MAP_BIT];
                  end
                  if (wstrb_r[0]) begin
                     memdrv_nxt = wdata_r[`BCC_MEMDRV_BIT];
                     clkdrv_nxt = wdata_r[`BCC_CLKDRV_BIT];
                  end
                  // Bits 4, 3, 2 and reserved ranges ignore writes
               end else begin
                  bresp_nxt = `AXI_RESP_SLVERR;
               end
            end else if (s_axi_bready) begin
               bvalid_nxt  = 1'b0;
               aw_have_nxt = 1'b0;
               w_have_nxt  = 1'b0;
               awready_nxt = 1'b1;
               wready_nxt  = 1'b1;
               wst_nxt     = WR_IDLE;
            end
         end
         default: begin
            wst_nxt     = WR_IDLE;
            aw_have_nxt = 1'b0;
            w_have_nxt  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wst_r     <= WR_IDLE;
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         awaddr_r  <= '0;
         wdata_r   <= 32'h0000_0000;
         wstrb_r   <= 4'h0;
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
         bvalid_r  <= 1'b0;
         bresp_r   <= `AXI_RESP_OKAY;
         map_r     <= `BCC_MAP_RST;
         memdrv_r  <= `BCC_MEMDRV_RST;
         clkdrv_r  <= `BCC_CLKDRV_RST;
      end else if (ce) begin
         wst_r     <= wst_nxt;
         aw_have_r <= aw_have_nxt;
         w_have_r  <= w_have_nxt;
         awaddr_r  <= awaddr_nxt;
         wdata_r   <= wdata_nxt;
         wstrb_r   <= wstrb_nxt;
         awready_r <= awready_nxt;
         wready_r  <= wready_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
         map_r     <= map_nxt;
         memdrv_r  <= memdrv_nxt;
         clkdrv_r  <= clkdrv_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   // Address taken with ready high in idle, data one cycle later
   always_comb begin
      rst_nxt     = rst_r;
      arready_nxt = arready_r;
      rvalid_nxt  = rvalid_r;
      rdata_nxt   = rdata_r;
      rresp_nxt   = rresp_r;
      unique case (rst_r)
         RD_IDLE: begin
            if (s_axi_arvalid && arready_r) begin
               arready_nxt = 1'b0;
               rvalid_nxt  = 1'b1;
               rst_nxt     = RD_RESP;
               if (hit(s_axi_araddr)) begin
                  rdata_nxt = reg_view;
                  rresp_nxt = `AXI_RESP_OKAY;
               end else begin
                  rdata_nxt = 32'h0000_0000;
                  rresp_nxt = `AXI_RESP_SLVERR;
               end
            end
         end
         RD_RESP: begin
            if (s_axi_rready) begin
               rvalid_nxt  = 1'b0;
               arready_nxt = 1'b1;
               rst_nxt     = RD_IDLE;
            end
         end
         default: begin
            rst_nxt = RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rst_r     <= RD_IDLE;
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0000_0000;
         rresp_r   <= `AXI_RESP_OKAY;
      end else if (ce) begin
         rst_r     <= rst_nxt;
         arready_r <= arready_nxt;
         rvalid_r  <= rvalid_nxt;
         rdata_r   <= rdata_nxt;
         rresp_r   <= rresp_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Setting outputs
   // ---------------------------------------------------------------
   // Registered copies so every output leaves from a flip-flop
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         endian_r <= 1'b0;
         card5_r  <= 1'b0;
         card6_r  <= 1'b0;
      end else if (ce) begin
         endian_r <= endian_cap;
         card5_r  <= map_nxt;
         card6_r  <= map_nxt;
      end
   end

   assign s_axi_awready            = awready_r;
   assign s_axi_wready             = wready_r;
   assign s_axi_bvalid             = bvalid_r;
   assign s_axi_bresp              = bresp_r;
   assign s_axi_arready            = arready_r;
   assign s_axi_rvalid             = rvalid_r;
   assign s_axi_rdata              = rdata_r;
   assign s_axi_rresp              = rresp_r;
   assign map_select               = map_r;
   assign little_endian            = endian_r;
   assign standby_memory_pin_drive = memdrv_r;
   assign standby_clock_pin_drive  = clkdrv_r;
   assign area5_card_enable        = card5_r;
   assign area6_card_enable        = card6_r;
endmodule
`default_nettype wire

// *** tb/bus_common_control_props.sv ***
// Checker for the bus common control register block
`timescale 1ns/1ps
`default_nettype none
`include "bus_common_cfg.svh"
module bus_common_control_props #(
   parameter int ADDR_W = 12
) (
   input wire logic              mclk,
   input wire logic              nrst,
   input wire logic              ce,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic [31:0]       s_axi_wdata,
   input wire logic [3:0]        s_axi_wstrb,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic [1:0]        s_axi_bresp,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [31:0]       s_axi_rdata,
   input wire logic [1:0]        s_axi_rresp,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready,
   input wire logic              byte_order_mode_pin,
   input wire logic              map_select,
   input wire logic              little_endian,
   input wire logic              standby_memory_pin_drive,
   input wire logic              standby_clock_pin_drive,
   input wire logic              area5_card_enable,
   input wire logic              area6_card_enable
);
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   logic [1:0] age_r;   // Enabled edges since release, saturates at 3
   logic [1:0] age_nxt; // Next age
   wire        ok_rd;   // Good read data on the bus
   assign ok_rd = s_axi_rvalid && (s_axi_rresp == `AXI_RESP_OKAY);
   // Age counts only run edges, since the capture waits for ce
   always_comb begin
      age_nxt = age_r;
      if (ce && (age_r != 2'h3)) begin
         age_nxt = age_r + 2'h1;
      end
   end
   // Cleared by reset so a second reset restarts the count
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         age_r <= 2'h0;
      end else begin
         age_r <= age_nxt;
      end
   end
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   AST_RSV_ZERO: assert property (ok_rd |-> s_axi_rdata[31:13] == 19'h0
      && s_axi_rdata[11:5] == 7'h0)
      else $error("reserved zero bits read nonzero");
   AST_RSV_ONE: assert property (ok_rd |-> s_axi_rdata[4] && s_axi_rdata[2])
      else $error("reserved one bits read zero");
   AST_MAP_IMAGE: assert property (ok_rd |-> s_axi_rdata[12] == map_select)
      else $error("map bit differs from map output");
   AST_ENDIAN_HOLD: assert property (age_r == 2'h3 |-> $stable(little_endian))
      else $error("byte order flag moved after capture");
   AST_ENDIAN_IMAGE: assert property (ok_rd && age_r[1]
      |-> s_axi_rdata[3] == little_endian)
      else $error("byte order bit differs from output");
   AST_MEM_DRIVE: assert property (ok_rd |-> s_axi_rdata[1] == standby_memory_pin_drive)
      else $error("memory pin drive differs from bit 1");
   AST_CLK_DRIVE: assert property (ok_rd |-> s_axi_rdata[0] == standby_clock_pin_drive)
      else $error("clock pin drive differs from bit 0");
   AST_CARD_MAP: assert property (area5_card_enable == map_select
      && area6_card_enable == map_select)
      else $error("card enables do not follow map");
   AST_WR_ONLY: assert property ($changed({map_select, standby_memory_pin_drive,
      standby_clock_pin_drive}) |-> $rose(s_axi_bvalid))
      else $error("setting changed without a write response");
   AST_BAD_ZERO: assert property (s_axi_rvalid && s_axi_rresp == `AXI_RESP_SLVERR
      |-> s_axi_rdata == 32'h0)
      else $error("refused read returned data");
   AST_WR_RESP: assert property (ce && s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   AST_RD_RESP: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   // Main scenarios reached
   COV_MAP2: cover property ($rose(map_select));
   COV_REFUSED: cover property (s_axi_rvalid && s_axi_rresp == `AXI_RESP_SLVERR);
   COV_LITTLE: cover property (ok_rd && s_axi_rdata[3]);
endmodule
`default_nettype wire

// *** tb/bus_common_control_tb_top.sv ***
// Testbench for the bus common control register block
`timescale 1ns/1ps
`default_nettype none
`include "bus_common_cfg.svh"
module bus_common_control_tb_top;
   // ---------------------------------------------------------------
   // Stimulus, observation and device
   // ---------------------------------------------------------------
   logic        mclk = 1'b0, nrst = 1'b0, ce = 1'b1, byte_order_mode_pin = 1'b0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        map_select, little_endian, standby_memory_pin_drive, standby_clock_pin_drive;
   logic        area5_card_enable, area6_card_enable;
   int          failures = 0, num_checks = 0, cycles = 0;
   logic [11:0] off = `BCC_OFFSET;
   always #25 mclk = ~mclk; // 20 MHz
   bus_common_control i_dut (.mclk, .nrst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .byte_order_mode_pin, .map_select, .little_endian,
      .standby_memory_pin_drive, .standby_clock_pin_drive, .area5_card_enable, .area6_card_enable);
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
         failures++;
      end
   endtask
   // Address and data offered together, each released when taken
   task automatic wchk(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                       input logic [1:0] er);
      bit aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge mclk);
         if (!aw_ok && s_axi_awready) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge mclk); while (!s_axi_bvalid);
      chk(32'(s_axi_bresp), 32'(er));
      s_axi_bready <= 1'b0;
      @(posedge mclk); // Keeps bready from being driven twice in one step
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge mclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge mclk); while (!s_axi_rvalid);
      chk(s_axi_rdata, ed);
      chk(32'(s_axi_rresp), 32'(er));
      s_axi_rready <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic do_reset(input logic p);
      nrst <= 1'b0;
      byte_order_mode_pin <= p;
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      repeat (2) @(posedge mclk); // Capture settles before the first read
   endtask
   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Hang guard, far above the hundred or so cycles the run needs
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         report_and_stop();
      end
   end
   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      do_reset(1'b0);
      rchk(off, 32'h0000_0014, `AXI_RESP_OKAY);
      chk(32'(little_endian), 32'h0);
      $display("Test reset image done");
      // Register is first written here, after only the reset image read
      wchk(off, 32'hFFFF_FFFF, 4'hF, `AXI_RESP_OKAY);
      rchk(off, 32'h0000_1017, `AXI_RESP_OKAY);
      chk(32'({map_select, area5_card_enable, area6_card_enable}), 32'h7);
      $display("Test all ones done");
      for (int v = 0; v < 4; v++) begin
         wchk(off, 32'h0000_0014 | 32'(v), 4'hF, `AXI_RESP_OKAY);
         rchk(off, 32'h0000_0014 | 32'(v), `AXI_RESP_OKAY);
         chk(32'({standby_memory_pin_drive, standby_clock_pin_drive}), 32'(v));
      end
      $display("Test standby drive done");
      // Lane 1 masked: map holds while the low lane clears both drives
      wchk(off, 32'h0000_1000, 4'h1, `AXI_RESP_OKAY);
      rchk(off, 32'h0000_0014, `AXI_RESP_OKAY);
      wchk(12'h004, 32'h0000_1000, 4'hF, `AXI_RESP_SLVERR);
      rchk(12'h004, 32'h0, `AXI_RESP_SLVERR);
      byte_order_mode_pin <= 1'b1;
      rchk(off, 32'h0000_0014, `AXI_RESP_OKAY);
      $display("Test masks and refusals done");
      wchk(off, 32'h0000_1014, 4'hF, `AXI_RESP_OKAY);
      do_reset(1'b1);
      rchk(off, 32'h0000_001C, `AXI_RESP_OKAY);
      chk(32'(little_endian), 32'h1);
      wchk(off, 32'h0000_0014, 4'hF, `AXI_RESP_OKAY);
      rchk(off, 32'h0000_001C, `AXI_RESP_OKAY);
      $display("Test second reset done");
      report_and_stop();
   end
endmodule
bind bus_common_control bus_common_control_props #(.ADDR_W(ADDR_W)) i_props (.mclk, .nrst,
   .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
   .byte_order_mode_pin, .map_select, .little_endian, .standby_memory_pin_drive,
   .standby_clock_pin_drive, .area5_card_enable, .area6_card_enable);
`default_nettype wire
